// ===== logic/dcai_pkg.sv
`default_nettype none
package dcai_pkg;
   // clock period in picoseconds (10 MHz)
   localparam int unsigned CLK_PERIOD_PS = 100000;
   // least and most times, in the unit each name ends with
   localparam int unsigned T_INIT_US     = 200;
   localparam int unsigned T_RC_NS       = 130;
   localparam int unsigned T_RAS_MIN_NS  = 70;
   localparam int unsigned T_RAS_MAX_NS  = 10000;
   localparam int unsigned T_RP_NS       = 50;
   localparam int unsigned T_CAS_NS      = 21;
   localparam int unsigned ROW_TO_COLUMN_STROBE_DELAY_MIN_NS  = 18;
   localparam int unsigned ROW_TO_COLUMN_STROBE_DELAY_MAX_NS  = 45;
   localparam int unsigned T_PC_NS       = 45;
   localparam int unsigned T_CP_NS       = 10;
   localparam int unsigned T_CPRH_NS     = 45;
   localparam int unsigned T_CSR_NS      = 15;
   localparam int unsigned T_CHR_NS      = 18;
   localparam int unsigned T_REF_MS      = 256;
   localparam int unsigned REF_ROWS      = 4096;
   localparam int unsigned INIT_REFRESHES = 8;
   // least times round up, longest round down, never below one cycle
   function automatic int unsigned dcai_up(input int unsigned ns);
      int unsigned c;
      c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction : dcai_up
   function automatic int unsigned dcai_dn(input int unsigned ns);
      int unsigned c;
      c = (ns * 1000) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction : dcai_dn
   localparam int unsigned CYC_INIT   = T_INIT_US * 10;
   localparam int unsigned CYC_RCD    = dcai_up(ROW_TO_COLUMN_STROBE_DELAY_MIN_NS);
   localparam int unsigned CYC_RCD_MX = dcai_dn(ROW_TO_COLUMN_STROBE_DELAY_MAX_NS);
   localparam int unsigned CYC_CAS    = dcai_up(T_CAS_NS);
   localparam int unsigned CYC_CP     = dcai_up(T_CP_NS);
   localparam int unsigned CYC_CPRH   = dcai_up(T_CPRH_NS);
   localparam int unsigned CYC_RAS    = dcai_up(T_RAS_MIN_NS);
   localparam int unsigned CYC_RAS_MX = dcai_dn(T_RAS_MAX_NS);
   localparam int unsigned CYC_RP     = dcai_up(T_RP_NS);
   localparam int unsigned CYC_CSR    = dcai_up(T_CSR_NS);
   localparam int unsigned CYC_CHR    = dcai_up(T_CHR_NS);
   // page beat budget: column, precharge, row hold and one spare
   localparam int unsigned CYC_PC_GUARD = CYC_CAS + CYC_CP + CYC_CPRH + 1;
   // refresh interval: 256 ms / 4096 rows = 62.5 us, rounded down
   localparam int unsigned CYC_REFI   =
      (T_REF_MS * 10000) / REF_ROWS;
   // access kinds
   typedef enum logic [1:0] {
      DCAI_OP_READ  = 2'h0,
      DCAI_OP_WRITE = 2'h1
   } dcai_op_type;
   // controller states, gray along the access path
   typedef enum logic [3:0] {
      DCAI_ST_INIT   = 4'h0,
      DCAI_ST_IDLE   = 4'h1,
      DCAI_ST_ROW    = 4'h3,
      DCAI_ST_COL    = 4'h2,
      DCAI_ST_CPRE   = 4'h6,
      DCAI_ST_RHOLD  = 4'h7,
      DCAI_ST_PRE    = 4'h5,
      DCAI_ST_RFCS   = 4'h4,
      DCAI_ST_RFRAS  = 4'hc,
      DCAI_ST_RFROW  = 4'hd
   } dcai_state_type;
endpackage : dcai_pkg
`default_nettype wire

// ===== logic/dcai_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module dcai_ctrl #(
   parameter int unsigned ROW_W     = 12,
   parameter int unsigned COL_W     = 10,
   parameter int unsigned DATA_W    = 32,
   parameter int unsigned BANKS     = 4,
   parameter int unsigned INIT_CYC  = dcai_pkg::CYC_INIT,
   parameter int unsigned REFI_CYC  = dcai_pkg::CYC_REFI,
   parameter bit          USE_CBR   = 1'b1
) (
   // clock and reset
   input  wire logic                sys_clk_i,
   input  wire logic                srst_i,
   // user request
   input  wire logic                req_valid_i,
   output logic                     req_ready_o,
   input  wire logic                req_write_i,
   input  wire logic                req_last_i,
   input  wire logic [1:0]          req_bank_i,
   input  wire logic [ROW_W-1:0]    req_row_i,
   input  wire logic [COL_W-1:0]    req_col_i,
   input  wire logic [DATA_W-1:0]   req_wdata_i,
   input  wire logic [3:0]          req_lanes_i,
   // user answer
   output logic                     rd_valid_o,
   output logic [DATA_W-1:0]        rd_data_o,
   output logic                     init_done_o,
   output logic [7:0]               card_config_o,
   // card pins
   output logic [BANKS-1:0]         row_strobe_n_o,
   output logic [3:0]               column_strobe_n_o,
   output logic                     write_n_o,
   output logic [ROW_W-1:0]         addr_o,
   input  wire logic [DATA_W-1:0]   data_lines_i,
   output logic [DATA_W-1:0]        data_lines_o,
   output logic                     data_lines_oe_o,
   input  wire logic [7:0]          card_config_straps_i
);
   import dcai_pkg::*;

   // whole state in one record, apart from the two-stage input synchronisers
   typedef struct packed {
      dcai_state_type       st;
      logic [15:0]          tmr;    // phase timer
      logic [15:0]          ras;    // row strobe low time
      logic [15:0]          refi;   // refresh interval
      logic [3:0]           ninit;
      logic                 ref_due;
      logic                 done;
      logic                 wr;
      logic                 last;
      logic [BANKS-1:0]     rsn;
      logic [3:0]           csn;
      logic                 wn;
      logic [ROW_W-1:0]     addr;
      logic [ROW_W-1:0]     rrow;   // refresh row counter
      logic [DATA_W-1:0]    dout;
      logic                 oe;
      logic [3:0]           lanes;
      logic                 rdv;
      logic [DATA_W-1:0]    rdat;
      logic [7:0]           cfg;
   } dcai_regs_type;

   dcai_regs_type r;
   dcai_regs_type next_r;
   logic [DATA_W-1:0] din_s1;
   logic [DATA_W-1:0] din_s2;
   logic [7:0]        cfg_s1;
   logic [7:0]        cfg_s2;

   // pin inputs pass two flip-flops
   always_ff @(posedge sys_clk_i) begin
      din_s1 <= data_lines_i;
      din_s2 <= din_s1;
      cfg_s1 <= card_config_straps_i;
      cfg_s2 <= cfg_s1;
   end

   // the controller is ready only in idle with no refresh pending
   assign req_ready_o = (r.st == DCAI_ST_IDLE) && !r.ref_due &&
                        (r.tmr == 16'h0000);

   // next-state logic
   always_comb begin
      next_r = r;
      next_r.rdv = 1'b0;
      next_r.cfg = cfg_s2;
      if (r.tmr != 16'h0000) begin
         next_r.tmr = r.tmr - 16'h0001;
      end
      if (r.rsn != {BANKS{1'b1}}) begin
         next_r.ras = r.ras + 16'h0001;
      end else begin
         next_r.ras = 16'h0000;
      end
      // distributed refresh pacing
      if (r.done) begin
         if (r.refi == 16'h0000) begin
            next_r.refi = 16'(REFI_CYC - 1);
            next_r.ref_due = 1'b1;
         end else begin
            next_r.refi = r.refi - 16'h0001;
         end
      end
      case (r.st)
         DCAI_ST_INIT: begin
            // power-up pause then burst of refreshes
            if (r.tmr == 16'h0000) begin
               next_r.ref_due = 1'b1;
               next_r.st = DCAI_ST_IDLE;
            end
         end
         DCAI_ST_IDLE: begin
            if (r.tmr == 16'h0000 && r.ref_due) begin
               if (USE_CBR) begin
                  // column first, write select high
                  next_r.csn = 4'h0;
                  next_r.wn = 1'b1;
                  next_r.tmr = 16'(CYC_CSR);
                  next_r.st = DCAI_ST_RFCS;
               end else begin
                  // row-only refresh with external row
                  next_r.addr = r.rrow;
                  next_r.rsn = {BANKS{1'b0}};
                  next_r.tmr = 16'(CYC_RAS);
                  next_r.st = DCAI_ST_RFROW;
               end
            end else if (req_valid_i && req_ready_o) begin
               // row address first, one bank only
               next_r.addr = req_row_i;
               next_r.rsn = ~(BANKS'(1) << req_bank_i);
               next_r.wr = req_write_i;
               next_r.last = req_last_i;
               next_r.lanes = req_lanes_i;
               next_r.wn = ~req_write_i;
               next_r.dout = req_wdata_i;
               next_r.tmr = 16'(CYC_RCD);
               next_r.st = DCAI_ST_ROW;
            end
         end
         DCAI_ST_ROW: begin
            // column address and strobe after row delay
            next_r.addr = ROW_W'(req_col_i);
            if (r.tmr == 16'h0000) begin
               next_r.csn = ~r.lanes;
               next_r.oe = r.wr;
               next_r.tmr = 16'(CYC_CAS);
               next_r.st = DCAI_ST_COL;
            end
         end
         DCAI_ST_COL: begin
            if (r.tmr == 16'h0000) begin
               // column strobe width met
               next_r.csn = 4'hf;
               next_r.oe = 1'b0;
               next_r.tmr = 16'(CYC_CP);
               next_r.st = DCAI_ST_CPRE;
            end
         end
         DCAI_ST_CPRE: begin
            // synced read data lags the pins by the two sync stages
            if (!r.wr && r.tmr == 16'(CYC_CP)) begin
               next_r.rdv = 1'b1;
               next_r.rdat = din_s2;
            end
            if (r.tmr == 16'h0000) begin
               if (!r.last && req_valid_i &&
                   r.ras < 16'(CYC_RAS_MX - CYC_PC_GUARD)) begin
                  // next page column
                  next_r.addr = ROW_W'(req_col_i);
                  next_r.dout = req_wdata_i;
                  next_r.last = req_last_i;
                  next_r.lanes = req_lanes_i;
                  next_r.csn = ~req_lanes_i;
                  next_r.oe = r.wr;
                  next_r.tmr = 16'(CYC_CAS);
                  next_r.st = DCAI_ST_COL;
               end else begin
                  next_r.tmr = 16'(CYC_CPRH);
                  next_r.st = DCAI_ST_RHOLD;
               end
            end
         end
         DCAI_ST_RHOLD: begin
            // row stays low after last column precharge
            if (r.tmr == 16'h0000 && r.ras >= 16'(CYC_RAS)) begin
               next_r.rsn = {BANKS{1'b1}};
               next_r.wn = 1'b1;
               next_r.tmr = 16'(CYC_RP);
               next_r.st = DCAI_ST_PRE;
            end
         end
         DCAI_ST_PRE: begin
            if (r.tmr == 16'h0000) begin
               next_r.st = DCAI_ST_IDLE;
            end
         end
         DCAI_ST_RFCS: begin
            if (r.tmr == 16'h0000) begin
               next_r.rsn = {BANKS{1'b0}};
               next_r.tmr = 16'(CYC_CHR);
               next_r.st = DCAI_ST_RFRAS;
            end
         end
         DCAI_ST_RFRAS: begin
            if (r.tmr == 16'h0000) begin
               next_r.csn = 4'hf;
               next_r.tmr = 16'(CYC_RAS - CYC_CHR);
               next_r.st = DCAI_ST_RFROW;
            end
         end
         DCAI_ST_RFROW: begin
            // finish a refresh cycle and count it
            if (r.tmr == 16'h0000) begin
               next_r.rsn = {BANKS{1'b1}};
               next_r.csn = 4'hf;
               next_r.rrow = r.rrow + ROW_W'(1);
               next_r.tmr = 16'(CYC_RP);
               next_r.st = DCAI_ST_PRE;
               if (!r.done) begin
                  next_r.ninit = r.ninit + 4'h1;
                  if (r.ninit == 4'(INIT_REFRESHES - 1)) begin
                     next_r.done = 1'b1;
                     next_r.ref_due = 1'b0;
                     next_r.refi = 16'(REFI_CYC - 1);
                  end
               end else begin
                  next_r.ref_due = 1'b0;
               end
            end
         end
         default: begin
            next_r.st = DCAI_ST_IDLE;
         end
      endcase
      if (r.done && r.refi == 16'h0000) begin
         next_r.ref_due = 1'b1; // set wins over clear
      end
   end

   // state register
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         r       <= '0;
         r.st    <= DCAI_ST_INIT;
         r.tmr   <= 16'(INIT_CYC);
         r.rsn   <= {BANKS{1'b1}};
         r.csn   <= 4'hf;
         r.wn    <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // pin and user outputs from flip-flops
   assign row_strobe_n_o    = r.rsn;
   assign column_strobe_n_o = r.csn;
   assign write_n_o         = r.wn;
   assign addr_o            = r.addr;
   assign data_lines_o      = r.dout;
   assign data_lines_oe_o   = r.oe;
   assign rd_valid_o        = r.rdv;
   assign rd_data_o         = r.rdat;
   assign init_done_o       = r.done;
   assign card_config_o     = r.cfg;

   // assertions
   ras_width_a: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      $rose(&r.rsn) && $past(r.st) != DCAI_ST_INIT
      |-> $past(r.ras) >= 16'(CYC_RAS))
      else $error("row strobe low too short");
   precharge_a: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      $rose(&r.rsn) |-> (&r.rsn) [*2])
      else $error("row precharge too short");
   ras_max_a: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      r.ras <= 16'(CYC_RAS_MX))
      else $error("row strobe low too long");
   one_bank_a: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      r.st == DCAI_ST_COL |-> $onehot(~r.rsn))
      else $error("more than one bank active");
   rd_wsel_a: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      $rose(|(~r.csn)) && !r.wr |-> $past(r.wn))
      else $error("write select low as read column fell");
   wsel_rd_a: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      (r.st == DCAI_ST_COL && !r.wr) |-> r.wn)
      else $error("write select low during read");
   wsel_wr_a: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      (r.st == DCAI_ST_COL && r.wr) |-> !r.wn && r.oe)
      else $error("write select high during write");
   init_wait_a: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      !r.done |-> !(r.st == DCAI_ST_ROW))
      else $error("access before init done");
   cbr_hold_a: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      $fell(&r.rsn) && r.st == DCAI_ST_RFRAS
      |-> (r.csn == 4'h0) [*2])
      else $error("column strobe not held in refresh");
   cas_first_a: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      r.st == DCAI_ST_ROW |-> r.csn == 4'hf)
      else $error("column strobe low before row");
   ras_to_cas_a: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      $fell(&r.rsn) && r.st == DCAI_ST_ROW |-> (r.csn == 4'hf) [*2])
      else $error("column strobe too soon after row");
   col_hold_a: assert property (
      @(posedge sys_clk_i) disable iff (srst_i)
      r.st == DCAI_ST_RHOLD |-> r.addr == $past(r.addr))
      else $error("column address moved before row rose");

   rd_c: cover property (@(posedge sys_clk_i) rd_valid_o);
   wr_c: cover property (@(posedge sys_clk_i) r.st == DCAI_ST_COL && r.wr);
   page_c: cover property (@(posedge sys_clk_i)
      r.st == DCAI_ST_CPRE ##1 r.st == DCAI_ST_COL);
   ref_c: cover property (@(posedge sys_clk_i) r.st == DCAI_ST_RFRAS);
   rfrow_c: cover property (@(posedge sys_clk_i)
      r.st == DCAI_ST_IDLE ##1 r.st == DCAI_ST_RFROW);
endmodule : dcai_ctrl
`default_nettype wire

// ===== tb/dcai_card_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcai_card_model (
   // card pins from the controller
   input  wire logic [3:0]  row_strobe_n_i,
   input  wire logic [3:0]  column_strobe_n_i,
   input  wire logic        write_n_i,
   input  wire logic [11:0] addr_i,
   input  wire logic [31:0] host_data_i,
   input  wire logic        host_oe_i,
   // resolved data wire
   output logic      [31:0] data_lines_o,
   // event counts for the bench
   output var int           refreshes,
   output var int           early_access,
   output var int           timing_viol
);
   logic [31:0] mem [int];
   logic [31:0] card_q   = 32'h0;
   logic [31:0] float_q  = 32'ha5a5_5a5a;
   logic        card_oe  = 1'b0;
   logic        col_seen = 1'b0;
   logic [11:0] row_q    = 12'h0;
   logic [1:0]  bank_q   = 2'h0;
   realtime     t_fall   = -1000.0;
   realtime     t_rise   = -1000.0;
   int          key;
   // counters start clear
   initial begin
      refreshes = 0;
      early_access = 0;
      timing_viol = 0;
   end
   // released lines carry a pattern that moves every 50 ns
   always #50 float_q = ~float_q;
   assign data_lines_o = host_oe_i ? host_data_i : (card_oe ? card_q : float_q);
   // row strobe falls: latch row and bank, spot column-first refresh
   always @(negedge (&row_strobe_n_i)) begin
      if ($realtime - t_rise < 50.0 || $realtime - t_fall < 130.0)
         timing_viol++;
      t_fall = $realtime;
      row_q = addr_i;
      for (int i = 0; i < 4; i++) begin
         if (!row_strobe_n_i[i]) bank_q = 2'(i);
      end
      col_seen = (column_strobe_n_i != 4'hf);
      if (col_seen) refreshes++;
   end
   // row strobe rises: pulse width, row-only refresh
   always @(posedge (&row_strobe_n_i)) begin
      if (t_fall > -1.0) begin
         if ($realtime - t_fall < 70.0 || $realtime - t_fall > 10000.0)
            timing_viol++;
         if (!col_seen) refreshes++;
         t_rise = $realtime;
      end
   end
   // column strobe falls inside a row cycle: one data beat
   always @(negedge (&column_strobe_n_i)) begin
      if (!(&row_strobe_n_i)) begin
         if (!col_seen && $realtime - t_fall < 18.0) timing_viol++;
         if (refreshes < 8) early_access++;
         col_seen = 1'b1;
         key = int'({bank_q, row_q, addr_i[9:0]});
         if (!write_n_i) begin
            #1;
            if (!mem.exists(key)) mem[key] = 32'h0;
            for (int i = 0; i < 4; i++) begin
               if (!column_strobe_n_i[i])
                  mem[key][8*i +: 8] = data_lines_o[8*i +: 8];
            end
         end else begin
            #25;
            card_q = mem.exists(key) ? mem[key] : 32'h0;
            card_oe = 1'b1;
         end
      end
   end
   // card lets go of the data lines shortly after the column strobe
   always @(posedge (&column_strobe_n_i)) begin
      #2;
      card_oe = 1'b0;
   end
endmodule : dcai_card_model
`default_nettype wire

// ===== tb/dram_card_async_interface_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dram_card_async_interface_tb;
   import dcai_pkg::*;
   localparam int unsigned INIT_T = 20;
   localparam int unsigned REFI_T = 60;
   logic        sys_clk_i   = 1'b0;
   logic        srst_i      = 1'b1;
   logic        req_valid_i = 1'b0;
   logic        req_write_i = 1'b0;
   logic        req_last_i  = 1'b0;
   logic [1:0]  req_bank_i  = 2'h0;
   logic [11:0] req_row_i   = 12'h0;
   logic [9:0]  req_col_i   = 10'h0;
   logic [31:0] req_wdata_i = 32'h0;
   logic [3:0]  req_lanes_i = 4'hf;
   logic [7:0]  straps      = 8'h5b;
   logic        req_ready_o, rd_valid_o, init_done_o, write_n_o, oe;
   logic [31:0] rd_data_o, host_data, data_bus;
   logic [7:0]  card_config_o;
   logic [3:0]  row_strobe_n_o, column_strobe_n_o;
   logic [11:0] addr_o;
   int          refreshes, early_access, timing_viol;
   int          failures = 0;
   int          checked  = 0;
   logic [31:0] rdq [$];
   // clock
   always #50 sys_clk_i = ~sys_clk_i;
   dcai_ctrl #(.INIT_CYC(INIT_T), .REFI_CYC(REFI_T)) dcai_ctrl_inst (
      .sys_clk_i(sys_clk_i), .srst_i(srst_i), .req_valid_i(req_valid_i),
      .req_ready_o(req_ready_o), .req_write_i(req_write_i),
      .req_last_i(req_last_i), .req_bank_i(req_bank_i), .req_row_i(req_row_i),
      .req_col_i(req_col_i), .req_wdata_i(req_wdata_i),
      .req_lanes_i(req_lanes_i), .rd_valid_o(rd_valid_o),
      .rd_data_o(rd_data_o), .init_done_o(init_done_o),
      .card_config_o(card_config_o), .row_strobe_n_o(row_strobe_n_o),
      .column_strobe_n_o(column_strobe_n_o), .write_n_o(write_n_o),
      .addr_o(addr_o), .data_lines_i(data_bus), .data_lines_o(host_data),
      .data_lines_oe_o(oe), .card_config_straps_i(straps));
   dcai_card_model dcai_card_model_inst (
      .row_strobe_n_i(row_strobe_n_o), .column_strobe_n_i(column_strobe_n_o),
      .write_n_i(write_n_o), .addr_i(addr_o), .host_data_i(host_data),
      .host_oe_i(oe), .data_lines_o(data_bus), .refreshes(refreshes),
      .early_access(early_access), .timing_viol(timing_viol));
   // second controller refreshes by row strobe alone, with no requests
   logic [3:0]  ro_rsn, ro_csn;
   logic [11:0] ro_addr;
   logic [31:0] ro_dout, ro_bus;
   logic        ro_wn, ro_oe, ro_done;
   int          ro_refs, ro_early, ro_viol;
   dcai_ctrl #(.INIT_CYC(INIT_T), .REFI_CYC(REFI_T), .USE_CBR(1'b0))
   dcai_ctrl_ro_inst (
      .sys_clk_i(sys_clk_i), .srst_i(srst_i), .req_valid_i(1'b0),
      .req_ready_o(), .req_write_i(1'b0), .req_last_i(1'b0),
      .req_bank_i(2'h0), .req_row_i(12'h000), .req_col_i(10'h000),
      .req_wdata_i(32'h0000_0000), .req_lanes_i(4'hf), .rd_valid_o(),
      .rd_data_o(), .init_done_o(ro_done), .card_config_o(),
      .row_strobe_n_o(ro_rsn), .column_strobe_n_o(ro_csn),
      .write_n_o(ro_wn), .addr_o(ro_addr), .data_lines_i(ro_bus),
      .data_lines_o(ro_dout), .data_lines_oe_o(ro_oe),
      .card_config_straps_i(straps));
   dcai_card_model dcai_card_model_ro_inst (
      .row_strobe_n_i(ro_rsn), .column_strobe_n_i(ro_csn),
      .write_n_i(ro_wn), .addr_i(ro_addr), .host_data_i(ro_dout),
      .host_oe_i(ro_oe), .data_lines_o(ro_bus), .refreshes(ro_refs),
      .early_access(ro_early), .timing_viol(ro_viol));
   // collect read words as they pulse out
   always @(posedge sys_clk_i) begin
      if (rd_valid_o === 1'b1) rdq.push_back(rd_data_o);
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t %s: saw %h want %h", $time, what, seen, exp);
      end
   endtask : check
   task automatic step;
      @(posedge sys_clk_i);
      #1;
   endtask : step
   task automatic conclude;
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   // one access or page burst; each beat ends when its column strobe rises
   task automatic burst(input logic wr, input logic [1:0] bank,
      input logic [11:0] row, input logic [9:0] col, input int n,
      input logic [31:0] base, input logic [3:0] lanes);
      int w;
      w = 0;
      req_valid_i = 1'b1;
      req_write_i = wr;
      req_bank_i = bank;
      req_row_i = row;
      req_lanes_i = lanes;
      for (int k = 0; k < n; k++) begin
         req_col_i = col + 10'(k);
         req_wdata_i = base + 32'(k);
         req_last_i = (k == n - 1);
         while (k == 0 && req_ready_o !== 1'b1 && w < 400) begin
            step();
            w++;
         end
         if (k == 0) step();
         while (column_strobe_n_o === 4'hf && w < 400) begin
            step();
            w++;
         end
         while (column_strobe_n_o !== 4'hf && w < 400) begin
            step();
            w++;
         end
      end
      req_valid_i = 1'b0;
      req_last_i = 1'b0;
      step();
      check(32'(w >= 400), 32'h0, "beat stalled");
   endtask : burst
   task automatic rd_check(input logic [1:0] bank, input logic [11:0] row,
      input logic [9:0] col, input int n, input logic [31:0] base);
      int w;
      w = 0;
      rdq.delete();
      burst(1'b0, bank, row, col, n, 32'h0, 4'hf);
      while (rdq.size() < n && w < 20) begin
         step();
         w++;
      end
      for (int k = 0; k < n; k++) begin
         check(rdq.size() > k ? rdq[k] : 32'hx, base + 32'(k), "read");
      end
   endtask : rd_check
   task automatic t_init;
      int w;
      w = 0;
      while (init_done_o !== 1'b1 && w < 1000) begin
         step();
         w++;
      end
      repeat (3) step();
      check(32'(init_done_o), 32'h1, "init done");
      check(32'(refreshes >= 8), 32'h1, "init refreshes");
      check(32'(card_config_o), 32'h5b, "straps");
      check(32'(ro_done), 32'h1, "row-only init done");
      check(32'(ro_refs >= 8), 32'h1, "row-only init");
      $display("test init done");
   endtask : t_init
   task automatic t_access;
      burst(1'b1, 2'h0, 12'h123, 10'h3ff, 1, 32'hdead_beef, 4'hf);
      rd_check(2'h0, 12'h123, 10'h3ff, 1, 32'hdead_beef);
      burst(1'b1, 2'h1, 12'hfff, 10'h010, 4, 32'h1000_0000, 4'hf);
      rd_check(2'h1, 12'hfff, 10'h010, 4, 32'h1000_0000);
      $display("test access done");
   endtask : t_access
   // same address in every bank, then a two-lane overwrite of bank 2
   task automatic t_banks;
      for (int b = 0; b < 4; b++) begin
         burst(1'b1, 2'(b), 12'h040, 10'h005, 1, 32'h1111_1111 * (b + 1), 4'hf);
      end
      burst(1'b1, 2'h2, 12'h040, 10'h005, 1, 32'hffff_ffff, 4'h5);
      for (int b = 0; b < 4; b++) begin
         rd_check(2'(b), 12'h040, 10'h005, 1,
                  b == 2 ? 32'h33ff_33ff : 32'h1111_1111 * (b + 1));
      end
      $display("test banks done");
   endtask : t_banks
   task automatic t_refresh;
      int r0;
      int r1;
      r0 = refreshes;
      r1 = ro_refs;
      repeat (3 * REFI_T) step();
      r0 = refreshes - r0;
      r1 = ro_refs - r1;
      check(32'(r0 >= 2 && r0 <= 4), 32'h1, "refresh rate");
      check(32'(r1 >= 2 && r1 <= 4), 32'h1, "row-only rate");
      $display("test refresh done");
   endtask : t_refresh
   // main sequence
   initial begin
      repeat (8) @(posedge sys_clk_i);
      #1;
      check(32'(row_strobe_n_o), 32'hf, "strobes in reset");
      check(32'(req_ready_o), 32'h0, "ready in reset");
      srst_i = 1'b0;
      t_init();
      t_access();
      t_banks();
      t_refresh();
      check(32'(timing_viol), 32'h0, "pin timing");
      check(32'(early_access), 32'h0, "early access");
      check(32'(ro_viol + ro_early), 32'h0, "row-only timing");
      conclude();
   end
   // watchdog
   initial begin
      #2000000;
      failures++;
      $display("[ERR] %0t watchdog expired", $time);
      conclude();
   end
endmodule : dram_card_async_interface_tb
`default_nettype wire
